// ### rtl/ebp_pkg.sv
// Constants, register map and types for the enhanced bridge PWM block.
// Assumes one system clock and an Avalon-MM slave port with 32-bit data.
// Notes on behaviour
// RULE_01 - Up to four outputs, ten-bit duty resolution
// RULE_02 - Mode field: 00 single,10 half,01 fwd,11 rev
// RULE_03 - Mode-select bits set output active polarity
// RULE_04 - First enable waits for new period start
// RULE_05 - Control register zero releases all pins
// RULE_06 - Pins unused by mode stay unclaimed
// RULE_07 - Half-bridge: A modulated, B complement
// RULE_08 - Half-bridge dead band delays activation, instruction cycles
// RULE_09 - Dead band beyond duty keeps output inactive
// RULE_10 - Forward: A active, D modulated, B,C inactive
// RULE_11 - Reverse: C active, B modulated, A,D inactive
// RULE_12 - Single mode outputs enabled only by steering
// RULE_13 - Time base: timer plus two clock/prescaler bits
// RULE_14 - Software clears direction bits of used pins
// RULE_15 - Outputs relocatable by alternate pin selects
// RULE_16 - Shutdown, restart, dead band, steering registers exist
// RULE_17 - Period match: clear timer, set output, latch duty
// RULE_18 - Time base equals duty: output goes inactive
// RULE_19 - Duty: eight high bits plus two control bits
// RULE_20 - Claimed idle outputs drive polarity inactive level
package ebp_pkg;
    // Word offsets on the register bus (byte address = 4 * index)
    localparam logic [3:0] OFS_MODULE_CTRL  = 4'h0;
    localparam logic [3:0] OFS_DUTY_HIGH    = 4'h1;
    localparam logic [3:0] OFS_PERIOD       = 4'h2;
    localparam logic [3:0] OFS_TIMER_CTRL   = 4'h3;
    localparam logic [3:0] OFS_TIMER_COUNT  = 4'h4;
    localparam logic [3:0] OFS_DEADBAND     = 4'h5;
    localparam logic [3:0] OFS_STEERING     = 4'h6;
    localparam logic [3:0] OFS_SHUTDOWN     = 4'h7;
    localparam logic [3:0] OFS_TIMER_SELECT = 4'h8;
    localparam logic [3:0] OFS_ALT_PIN      = 4'h9;
    localparam logic [3:0] OFS_STATUS       = 4'hA;
    // Field positions
    localparam int MODE_LSB     = 6;  // bridge_mode_field [7:6]
    localparam int DUTY_LO_LSB  = 4;  // duty_low_bits [5:4]
    localparam int PWM_SEL_LSB  = 2;  // polarity_mode_bits [3:2] = 11
    localparam int POL_AC_BIT   = 1;  // A,C active low when set
    localparam int POL_BD_BIT   = 0;  // B,D active low when set
    localparam int RUN_BIT      = 2;  // timer_run_bit
    localparam int PRESC_LSB    = 0;  // prescale_select [1:0]
    // Encodings and reset values
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_FWD    = 2'h1;
    localparam logic [1:0] MODE_HALF   = 2'h2;
    localparam logic [1:0] MODE_REV    = 2'h3;
    localparam logic [1:0] PWM_SEL     = 2'h3;
    localparam logic [7:0] RST_REG     = 8'h00;
    localparam logic [7:0] RST_PERIOD  = 8'hFF;
    // Timing: one instruction cycle is four oscillator periods
    localparam int INSTR_OSC_PERIODS = 4;
    localparam real CLK_PERIOD_NS    = 4.0;
    localparam real OSC_PERIOD_NS    = 4.0;
    localparam int CYC_PER_INSTR     =
        int'(INSTR_OSC_PERIODS * OSC_PERIOD_NS / CLK_PERIOD_NS);
    localparam logic [5:0] PRESC_MAX_1  = 6'(CYC_PER_INSTR - 1);
    localparam logic [5:0] PRESC_MAX_4  = 6'(CYC_PER_INSTR * 4 - 1);
    localparam logic [5:0] PRESC_MAX_16 = 6'(CYC_PER_INSTR * 16 - 1);

    typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} ebp_run_t;

    // Pin group towards the gate drivers
    typedef struct packed {
        logic [3:0] lvl;     // Level for outputs d,c,b,a
        logic [3:0] oe_pri;  // Driving primary location
        logic [3:0] oe_alt;  // Driving alternate location
    } ebp_pins_t;

    // Whole state of the block
    typedef struct packed {
        logic [7:0]  module_ctrl;
        logic [7:0]  duty_high;
        logic [7:0]  period;
        logic [7:0]  timer_ctrl;
        logic [7:0]  timer_count;
        logic [7:0]  deadband;
        logic [7:0]  steering;
        logic [7:0]  shutdown;
        logic [7:0]  timer_select;
        logic [7:0]  alt_pin;
        logic [5:0]  presc;
        logic [9:0]  duty_shadow;
        logic        raw;
        ebp_run_t    run;
        logic [8:0]  dly_a;
        logic [8:0]  dly_b;
        ebp_pins_t   pins;
        logic        ack;
        logic [31:0] rdata;
    } ebp_state_t;
endpackage : ebp_pkg

// ### rtl/ebp_pwm.sv
// Enhanced bridge PWM generator with Avalon-MM register slave.
// Assumes a 250 MHz clock used directly as the oscillator, and that
// software sets port directions for every pin this block claims.
`timescale 1ns/1ps
module ebp_pwm
(
    input  wire logic              ref_clk_in,        // System clock
    input  wire logic              reset_in,          // Async reset, high
    input  wire logic [3:0]        avs_address_in,    // Word address
    input  wire logic              avs_read_in,       // Read request
    input  wire logic              avs_write_in,      // Write request
    input  wire logic [31:0]       avs_writedata_in,  // Write data
    input  wire logic [3:0]        avs_byteenable_in, // Byte lanes
    output logic [31:0]            avs_readdata_out,  // Read data
    output logic                   avs_waitrequest_out, // Stall
    output ebp_pkg::ebp_pins_t     pins_out           // Pin levels, enables
);

    ebp_pkg::ebp_state_t s_r;
    ebp_pkg::ebp_state_t s_nxt;

    logic        req;
    logic        wr;
    logic        pwm_mode;
    logic [1:0]  mode;
    logic        tick;
    logic        rollover;
    logic [1:0]  tb_low;
    logic [9:0]  timebase;
    logic [9:0]  tb_next;
    logic [9:0]  duty_new;
    logic [8:0]  db_load;
    logic [3:0]  act;
    logic [3:0]  claim;
    logic [3:0]  low;
    logic        gen_on;

    // Prescaler wrap value for the selected ratio
    function automatic logic [5:0] presc_max(input logic [1:0] sel);
        case (sel)
            2'h0:    presc_max = ebp_pkg::PRESC_MAX_1;
            2'h1:    presc_max = ebp_pkg::PRESC_MAX_4;
            default: presc_max = ebp_pkg::PRESC_MAX_16;
        endcase
    endfunction

    // Low time base bits: clock phase at 1:1, prescaler bits otherwise
    function automatic logic [1:0] tb_lsb(input logic [1:0] sel,
                                          input logic [5:0] p);
        case (sel)
            2'h0:    tb_lsb = p[1:0];
            2'h1:    tb_lsb = p[3:2];
            default: tb_lsb = p[5:4];
        endcase
    endfunction

    // Register read mux, unmapped words read as zero
    function automatic logic [31:0] read_mux(input ebp_pkg::ebp_state_t st,
                                             input logic [3:0] a);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            ebp_pkg::OFS_MODULE_CTRL:  v = st.module_ctrl;
            ebp_pkg::OFS_DUTY_HIGH:    v = st.duty_high;
            ebp_pkg::OFS_PERIOD:       v = st.period;
            ebp_pkg::OFS_TIMER_CTRL:   v = st.timer_ctrl;
            ebp_pkg::OFS_TIMER_COUNT:  v = st.timer_count;
            ebp_pkg::OFS_DEADBAND:     v = st.deadband;
            ebp_pkg::OFS_STEERING:     v = st.steering;
            ebp_pkg::OFS_SHUTDOWN:     v = st.shutdown;
            ebp_pkg::OFS_TIMER_SELECT: v = st.timer_select;
            ebp_pkg::OFS_ALT_PIN:      v = st.alt_pin;
            default:                   v = 8'h00;
        endcase
        if (a == ebp_pkg::OFS_STATUS)
            read_mux = {16'h0000, 2'(st.run), st.raw, 3'h0,
                        st.duty_shadow};
        else
            read_mux = {24'h000000, v};
    endfunction

    // Decoded views of the control registers
    assign req      = avs_read_in | avs_write_in;
    assign wr       = avs_write_in & s_r.ack & avs_byteenable_in[0];
    assign mode     = s_r.module_ctrl[ebp_pkg::MODE_LSB +: 2];
    assign pwm_mode = (s_r.module_ctrl[ebp_pkg::PWM_SEL_LSB +: 2]
                       == ebp_pkg::PWM_SEL);
    assign low      = {s_r.module_ctrl[ebp_pkg::POL_BD_BIT],
                       s_r.module_ctrl[ebp_pkg::POL_AC_BIT],
                       s_r.module_ctrl[ebp_pkg::POL_BD_BIT],
                       s_r.module_ctrl[ebp_pkg::POL_AC_BIT]}; // RULE_03
    assign gen_on   = (s_r.run == ebp_pkg::ST_RUN);
    assign duty_new = {s_r.duty_high,
                       s_r.module_ctrl[ebp_pkg::DUTY_LO_LSB +: 2]}; // RULE_19
    assign db_load  = {s_r.deadband[6:0], 2'b00}; // RULE_08

    // Time base: low bits come from the clock phase or the prescaler
    assign tb_low   = tb_lsb(s_r.timer_ctrl[ebp_pkg::PRESC_LSB +: 2],
                             s_r.presc);
    assign timebase = {s_r.timer_count, tb_low}; // RULE_13
    assign tick     = s_r.timer_ctrl[ebp_pkg::RUN_BIT] &
                      (s_r.presc ==
                       presc_max(s_r.timer_ctrl[ebp_pkg::PRESC_LSB +: 2]));
    assign rollover = tick & (s_r.timer_count == s_r.period); // RULE_17

    // Per-mode steering of the modulated signal onto the four outputs
    always_comb
    begin
        act   = 4'h0;
        claim = 4'h0;
        case (mode)
            ebp_pkg::MODE_SINGLE:
            begin
                claim = s_r.steering[3:0]; // RULE_12
                act   = {4{s_r.raw & gen_on}} & s_r.steering[3:0];
            end
            ebp_pkg::MODE_HALF:
            begin
                claim = 4'h3; // RULE_06
                act[0] = gen_on & s_r.raw & (s_r.dly_a == 9'h000); // RULE_07
                act[1] = gen_on & ~s_r.raw & (s_r.dly_b == 9'h000); // RULE_09
            end
            ebp_pkg::MODE_FWD:
            begin
                claim = 4'hF;
                act   = {s_r.raw & gen_on, 1'b0, 1'b0, gen_on}; // RULE_10
            end
            ebp_pkg::MODE_REV:
            begin
                claim = 4'hF;
                act   = {1'b0, gen_on, s_r.raw & gen_on, 1'b0}; // RULE_11
            end
            default:
            begin
                claim = 4'h0;
                act   = 4'h0;
            end
        endcase
        if (!pwm_mode)
            claim = 4'h0; // RULE_05
    end

    // Next state: bus slave, timer, duty buffer, dead band and pins
    always_comb
    begin
        s_nxt = s_r;
        // One wait state, then the answer; read data loaded meanwhile
        s_nxt.ack = req & ~s_r.ack;
        if (req && !s_r.ack)
            s_nxt.rdata = read_mux(s_r, avs_address_in);
        // Timer and prescaler
        if (s_r.timer_ctrl[ebp_pkg::RUN_BIT])
            s_nxt.presc = tick ? 6'h00 : 6'(s_r.presc + 6'h01);
        if (tick)
            s_nxt.timer_count = rollover ? 8'h00
                                         : 8'(s_r.timer_count + 8'h01);
        // Time base as it will stand after this edge
        tb_next = {s_nxt.timer_count,
                   tb_lsb(s_r.timer_ctrl[ebp_pkg::PRESC_LSB +: 2],
                          s_nxt.presc)};
        // Start only on a period boundary so no partial pulse leaks
        case (s_r.run)
            ebp_pkg::ST_IDLE:
                if (pwm_mode)
                    s_nxt.run = ebp_pkg::ST_ARMED;
            ebp_pkg::ST_ARMED:
                if (!pwm_mode)
                    s_nxt.run = ebp_pkg::ST_IDLE;
                else if (rollover)
                    s_nxt.run = ebp_pkg::ST_RUN; // RULE_04
            ebp_pkg::ST_RUN:
                if (!pwm_mode)
                    s_nxt.run = ebp_pkg::ST_IDLE;
            default:
                s_nxt.run = ebp_pkg::ST_IDLE;
        endcase
        // Period start sets, duty match clears; set wins on collision
        if (rollover && pwm_mode)
        begin
            s_nxt.duty_shadow = duty_new; // RULE_17
            s_nxt.raw         = (duty_new != 10'h000);
        end
        else if (!pwm_mode)
            s_nxt.raw = 1'b0;
        // Clear on the coming match so the pulse lasts exactly the duty
        else if (timebase == s_r.duty_shadow
                 || tb_next == s_r.duty_shadow)
            s_nxt.raw = 1'b0; // RULE_18
        // Dead band counters reload while their side is inactive
        if (!s_r.raw)
            s_nxt.dly_a = db_load;
        else if (s_r.dly_a != 9'h000)
            s_nxt.dly_a = 9'(s_r.dly_a - 9'h001); // RULE_08
        if (s_r.raw)
            s_nxt.dly_b = db_load;
        else if (s_r.dly_b != 9'h000)
            s_nxt.dly_b = 9'(s_r.dly_b - 9'h001); // RULE_08
        // Pins: active xor polarity gives the inactive level when idle
        s_nxt.pins.lvl    = act ^ low; // RULE_20
        s_nxt.pins.oe_pri = claim & ~s_r.alt_pin[3:0]; // RULE_15
        s_nxt.pins.oe_alt = claim & s_r.alt_pin[3:0]; // RULE_01
        // Register writes take effect at the answering edge
        if (wr)
        begin
            case (avs_address_in)
                ebp_pkg::OFS_MODULE_CTRL:
                    s_nxt.module_ctrl = avs_writedata_in[7:0]; // RULE_02
                ebp_pkg::OFS_DUTY_HIGH:
                    s_nxt.duty_high = avs_writedata_in[7:0];
                ebp_pkg::OFS_PERIOD:
                    s_nxt.period = avs_writedata_in[7:0];
                ebp_pkg::OFS_TIMER_CTRL:
                    s_nxt.timer_ctrl = {1'b0, avs_writedata_in[6:0]};
                ebp_pkg::OFS_TIMER_COUNT:
                    s_nxt.timer_count = avs_writedata_in[7:0];
                ebp_pkg::OFS_DEADBAND:
                    s_nxt.deadband = avs_writedata_in[7:0]; // RULE_16
                ebp_pkg::OFS_STEERING:
                    s_nxt.steering = {4'h0, avs_writedata_in[3:0]};
                ebp_pkg::OFS_SHUTDOWN:
                    s_nxt.shutdown = avs_writedata_in[7:0];
                ebp_pkg::OFS_TIMER_SELECT:
                    s_nxt.timer_select = avs_writedata_in[7:0];
                ebp_pkg::OFS_ALT_PIN:
                    s_nxt.alt_pin = {4'h0, avs_writedata_in[3:0]};
                default:
                    s_nxt.alt_pin = s_r.alt_pin;
            endcase
        end
    end

    // State register
    always_ff @(posedge ref_clk_in or posedge reset_in)
    begin
        if (reset_in)
        begin
            s_r              <= '0;
            s_r.period       <= ebp_pkg::RST_PERIOD;
            s_r.module_ctrl  <= ebp_pkg::RST_REG;
            s_r.run          <= ebp_pkg::ST_IDLE;
        end
        else
            s_r <= s_nxt;
    end

    // Bus answer and pins; waitrequest drops in the answering cycle
    assign avs_waitrequest_out = req & ~s_r.ack;
    assign avs_readdata_out    = s_r.rdata;
    assign pins_out            = s_r.pins;

    // Checks on the generated waveform and pin ownership
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);

    sequence seq_rollover;
        rollover && pwm_mode;
    endsequence

    sequence seq_half_zero_db;
        mode == ebp_pkg::MODE_HALF && pwm_mode && gen_on &&
        s_r.deadband[6:0] == 7'h00 && low == 4'h0 &&
        s_r.dly_a == 9'h000 && s_r.dly_b == 9'h000;
    endsequence

    sequence seq_pulse_end;
        pwm_mode && !rollover && tb_next == s_r.duty_shadow;
    endsequence

    a_roll_latch: assert property (seq_rollover // RULE_17
        |=> s_r.timer_count == 8'h00
        && s_r.duty_shadow == $past(duty_new)
        && s_r.raw == ($past(duty_new) != 10'h000))
        else $error("period match did not restart the cycle");

    a_match_clear: assert property (pwm_mode && !rollover // RULE_18
        && timebase == s_r.duty_shadow |=> !s_r.raw)
        else $error("duty match did not end the pulse");

    // Pulse length is pinned by the coming-match clear
    a_pulse_end: assert property (seq_pulse_end |=> !s_r.raw) // RULE_18
        else $error("pulse outlived the duty value");

    a_shadow_hold: assert property (!rollover // RULE_17
        |=> s_r.duty_shadow == $past(s_r.duty_shadow))
        else $error("duty buffer changed inside a period");

    a_armed_quiet: assert property (s_r.run == ebp_pkg::ST_ARMED // RULE_04
        |=> s_r.pins.lvl == $past(low))
        else $error("output active before first period start");

    a_release_zero: assert property (s_r.module_ctrl == 8'h00 // RULE_05
        |=> s_r.pins.oe_pri == 4'h0 && s_r.pins.oe_alt == 4'h0)
        else $error("pins still claimed with control cleared");

    a_half_unused: assert property (mode == ebp_pkg::MODE_HALF // RULE_06
        |=> s_r.pins.oe_pri[3:2] == 2'b00
            && s_r.pins.oe_alt[3:2] == 2'b00)
        else $error("half-bridge claimed outputs c or d");

    a_half_compl: assert property (seq_half_zero_db // RULE_07
        |=> s_r.pins.lvl[0] == $past(s_r.raw)
            && s_r.pins.lvl[1] == !$past(s_r.raw))
        else $error("half-bridge outputs not complementary");

    a_dead_hold: assert property (mode == ebp_pkg::MODE_HALF // RULE_08
        && s_r.raw && s_r.dly_a != 9'h000
        |=> s_r.pins.lvl[0] == $past(low[0]))
        else $error("output a went active inside dead band");

    a_fwd_levels: assert property (mode == ebp_pkg::MODE_FWD // RULE_10
        && gen_on && pwm_mode
        |=> s_r.pins.lvl[2:0] == ($past(low[2:0]) ^ 3'h1))
        else $error("forward mode static outputs wrong");

    a_rev_levels: assert property (mode == ebp_pkg::MODE_REV // RULE_11
        && gen_on && pwm_mode |=> s_r.pins.lvl[3] == $past(low[3])
            && s_r.pins.lvl[0] == $past(low[0])
            && s_r.pins.lvl[2] == !$past(low[2]))
        else $error("reverse mode static outputs wrong");

    // Claim follows steering alone, whatever the pin location
    a_steer_claim: assert property (mode == ebp_pkg::MODE_SINGLE // RULE_12
        && pwm_mode |=> (s_r.pins.oe_pri | s_r.pins.oe_alt)
            == $past(s_r.steering[3:0]))
        else $error("single mode claim differs from steering");

    a_alt_route: assert property (pwm_mode && s_r.alt_pin[0] // RULE_15
        && (mode != ebp_pkg::MODE_SINGLE || s_r.steering[0])
        |=> s_r.pins.oe_alt[0] && !s_r.pins.oe_pri[0])
        else $error("output a not moved to its alternate pin");

    // Software writes to the count are left out on purpose
    a_tick_count: assert property (tick && !rollover // RULE_13
        && !(wr && avs_address_in == ebp_pkg::OFS_TIMER_COUNT)
        |=> s_r.timer_count == 8'($past(s_r.timer_count) + 8'h01))
        else $error("time base did not advance on the tick");

    a_bus_answer: assert property (req && !s_r.ack
        |=> !avs_waitrequest_out ##1 !s_r.ack)
        else $error("bus answer not given after one wait state");

endmodule // ebp_pwm

// ### bench/ebp_gate_model.sv
// Gate driver model that sits on the pin side of the bridge PWM block.
// Assumes the pin group struct of ebp_pkg and one shared clock.
`timescale 1ns/1ps
module ebp_gate_model
(
    input  wire logic               clk_in,      // System clock
    input  wire logic               reset_in,    // Async reset, high
    input  wire ebp_pkg::ebp_pins_t pins_in,     // Levels and enables
    output logic [3:0]              pad_pri_out, // Primary pad level
    output logic [3:0]              pad_alt_out  // Alternate pad level
);
    logic [3:0] last_r;

    // Remember what each pin last drove
    always_ff @(posedge clk_in or posedge reset_in)
    begin
        if (reset_in)
            last_r <= 4'h0;
        else
            for (int i = 0; i < 4; i++)
                if (pins_in.oe_pri[i] | pins_in.oe_alt[i])
                    last_r[i] <= pins_in.lvl[i];
    end

    // Undriven pads show the inverse so stale data never looks valid
    always_comb
    begin
        for (int i = 0; i < 4; i++)
        begin
            pad_pri_out[i] = pins_in.oe_pri[i] ? pins_in.lvl[i]
                                               : ~last_r[i];
            pad_alt_out[i] = pins_in.oe_alt[i] ? pins_in.lvl[i]
                                               : ~last_r[i];
        end
    end
endmodule // ebp_gate_model

// ### bench/ebp_pwm_tb.sv
// Self-checking bench for the bridge PWM block over Avalon-MM.
// Assumes the gate driver model and the register map of ebp_pkg.
`timescale 1ns/1ps
module ebp_pwm_tb;
    logic               ref_clk;
    logic               rst;
    logic [3:0]         addr;
    logic               rd;
    logic               wr;
    logic [31:0]        wdata;
    logic [3:0]         be;
    logic [31:0]        rdata;
    logic               wait_s;
    ebp_pkg::ebp_pins_t pins;
    logic [3:0]         pad_pri;
    logic [3:0]         pad_alt;
    logic [31:0]        q;
    int                 errors;
    int                 tests_run;
    int                 cyc;
    int                 act;
    int                 rise;

    ebp_pwm i_dut (.ref_clk_in(ref_clk), .reset_in(rst),
        .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdata), .avs_byteenable_in(be),
        .avs_readdata_out(rdata), .avs_waitrequest_out(wait_s),
        .pins_out(pins));
    ebp_gate_model i_gate (.clk_in(ref_clk), .reset_in(rst),
        .pins_in(pins), .pad_pri_out(pad_pri), .pad_alt_out(pad_alt));

    // 250 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // One bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [7:0] d, output logic [31:0] r);
        begin
            @(posedge ref_clk);
            addr  <= a;
            wdata <= {24'h000000, d};
            rd    <= ~w;
            wr    <= w;
            @(posedge ref_clk);
            // Waitrequest drops after one wait state and ends this wait
            while (wait_s !== 1'b0)
                @(posedge ref_clk);
            r = rdata;
            rd <= 1'b0;
            wr <= 1'b0;
        end
    endtask

    task automatic wreg(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        tests_run++;
        if (g !== e)
        begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // High cycles and rising edges of one primary pad over a window
    task automatic meas(input int idx, input int n);
        logic prev;
        act  = 0;
        rise = 0;
        @(posedge ref_clk);
        #1 prev = pad_pri[idx];
        repeat (n)
        begin
            @(posedge ref_clk);
            #1;
            if (pad_pri[idx] === 1'b1) act++;
            if (pad_pri[idx] === 1'b1 && prev === 1'b0) rise++;
            prev = pad_pri[idx];
        end
    endtask

    task automatic chk_pin(input int idx, input int e);
        meas(idx, 32);
        chk($sformatf("pad %0d high cycles", idx), e, act);
    endtask

    // Period 3 gives 16 clocks per period at 1:1
    task automatic cfg(input logic [7:0] ctrl, input logic [7:0] dh,
                       input logic [1:0] ps, input logic [7:0] db,
                       input logic [7:0] st);
        wreg(ebp_pkg::OFS_PERIOD, 8'h03);
        wreg(ebp_pkg::OFS_DUTY_HIGH, dh);
        wreg(ebp_pkg::OFS_DEADBAND, db);
        wreg(ebp_pkg::OFS_STEERING, st);
        wreg(ebp_pkg::OFS_TIMER_CTRL, {5'h00, 1'b1, ps});
        wreg(ebp_pkg::OFS_MODULE_CTRL, ctrl);
        repeat (600) @(posedge ref_clk);
    endtask

    task automatic t_regs;
        bus(1'b0, ebp_pkg::OFS_PERIOD, 8'h00, q);
        chk("period reset", 32'h000000FF, q);
        bus(1'b0, ebp_pkg::OFS_MODULE_CTRL, 8'h00, q);
        chk("control reset", 32'h00000000, q);
        wreg(ebp_pkg::OFS_DEADBAND, 8'h85);
        bus(1'b0, ebp_pkg::OFS_DEADBAND, 8'h00, q);
        chk("deadband readback", 32'h00000085, q);
        @(posedge ref_clk);
        be <= 4'h0;
        wreg(ebp_pkg::OFS_STEERING, 8'h0F);
        @(posedge ref_clk);
        be <= 4'hF;
        bus(1'b0, ebp_pkg::OFS_STEERING, 8'h00, q);
        chk("masked write", 32'h00000000, q);
        wreg(4'hB, 8'h5A);
        bus(1'b0, 4'hB, 8'h00, q);
        chk("unmapped read", 32'h00000000, q);
        $display("t_regs done");
    endtask

    task automatic t_arm;
        wreg(ebp_pkg::OFS_PERIOD, 8'h03);
        wreg(ebp_pkg::OFS_DUTY_HIGH, 8'h01);
        wreg(ebp_pkg::OFS_STEERING, 8'h01);
        wreg(ebp_pkg::OFS_MODULE_CTRL, 8'h0C);
        repeat (40) @(posedge ref_clk);
        chk("oe while armed", 32'h1, {28'h0, pins.oe_pri});
        chk("level while armed", 32'h0, {28'h0, pins.lvl});
        wreg(ebp_pkg::OFS_TIMER_CTRL, 8'h04);
        repeat (40) @(posedge ref_clk);
        chk("oe after rollover", 32'h1, {28'h0, pins.oe_pri});
        bus(1'b0, ebp_pkg::OFS_STATUS, 8'h00, q);
        chk("run state", 32'h2, {30'h0, q[15:14]});
        chk("latched duty", 32'h4, {22'h0, q[9:0]});
        $display("t_arm done");
    endtask

    task automatic t_single;
        cfg(8'h0C, 8'h01, 2'h0, 8'h00, 8'h0A);
        chk("steered oe", 32'hA, {28'h0, pins.oe_pri});
        chk_pin(1, 8);
        chk_pin(3, 8);
        cfg(8'h2C, 8'h01, 2'h0, 8'h00, 8'h01);
        chk_pin(0, 12);
        cfg(8'h0C, 8'h00, 2'h0, 8'h00, 8'h01);
        chk_pin(0, 0);
        $display("t_single done");
    endtask

    task automatic t_modes;
        cfg(8'h8C, 8'h02, 2'h0, 8'h00, 8'h00);
        chk("half oe", 32'h3, {28'h0, pins.oe_pri});
        chk_pin(0, 16);
        repeat (16)
        begin
            @(posedge ref_clk);
            #1;
            chk("b complement", {31'h0, !pad_pri[0]},
                {31'h0, pad_pri[1]});
        end
        cfg(8'h8C, 8'h02, 2'h0, 8'h01, 8'h00);
        chk_pin(0, 8);
        chk_pin(1, 8);
        cfg(8'h8C, 8'h02, 2'h0, 8'h03, 8'h00);
        chk_pin(0, 0);
        chk_pin(1, 0);
        cfg(8'h4C, 8'h01, 2'h0, 8'h00, 8'h00);
        chk("full oe", 32'hF, {28'h0, pins.oe_pri});
        chk_pin(0, 32);
        chk_pin(1, 0);
        chk_pin(2, 0);
        chk_pin(3, 8);
        cfg(8'hCC, 8'h01, 2'h0, 8'h00, 8'h00);
        chk_pin(0, 0);
        chk_pin(1, 8);
        chk_pin(2, 32);
        chk_pin(3, 0);
        cfg(8'h4F, 8'h01, 2'h0, 8'h00, 8'h00);
        chk_pin(0, 0);
        chk_pin(1, 32);
        chk_pin(2, 32);
        chk_pin(3, 24);
        $display("t_modes done");
    endtask

    task automatic t_presc;
        for (int ps = 0; ps < 3; ps++)
        begin
            cfg(8'h0C, 8'h01, ps[1:0], 8'h00, 8'h01);
            meas(0, 256);
            chk("prescaled high cycles", 64, act);
            chk("periods in window", 16 >> (2 * ps), rise);
        end
        $display("t_presc done");
    endtask

    task automatic t_release;
        cfg(8'h0C, 8'h01, 2'h0, 8'h00, 8'h01);
        wreg(ebp_pkg::OFS_ALT_PIN, 8'h01);
        repeat (4) @(posedge ref_clk);
        chk("moved oe", 32'h10, {24'h0, pins.oe_alt, pins.oe_pri});
        wreg(ebp_pkg::OFS_MODULE_CTRL, 8'h00);
        repeat (4) @(posedge ref_clk);
        chk("released oe", 32'h0, {24'h0, pins.oe_alt, pins.oe_pri});
        $display("t_release done");
    endtask

    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard, well above the expected run length
    always @(posedge ref_clk)
    begin
        cyc = cyc + 1;
        if (cyc == 40000)
        begin
            errors++;
            give_verdict();
        end
    end

    // Main sequence
    initial
    begin
        rst = 1'b1;
        addr = 4'h0;
        rd = 1'b0;
        wr = 1'b0;
        wdata = 32'h0;
        be = 4'hF;
        errors = 0;
        tests_run = 0;
        cyc = 0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_arm();
        t_single();
        t_modes();
        t_presc();
        t_release();
        give_verdict();
    end
endmodule // ebp_pwm_tb
